// [rtl/compare_buffer.sv]
// one compare value with a shadow copy for period-aligned updates
// assumes load is a one-cycle pulse on the timer period boundary
`timescale 1ns/1ps
module compare_buffer (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  input wire logic buffered,
  input wire logic load,
  output logic [15:0] shadow_q,
  output logic [15:0] active_q
);
  import oc_pkg::*;
  buf_state_t s_q, s_d;

  // write to shadow; active follows at once or at the boundary
  always_comb begin
    s_d = s_q;
    if (wr_en) begin
      s_d.shadow = wr_data;
    end
    if (!buffered && wr_en) begin
      s_d.active = wr_data; // [R5]
    end else if (buffered && load) begin
      s_d.active = wr_en ? wr_data : s_q.shadow; // [R5]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign shadow_q = s_q.shadow;
  assign active_q = s_q.active;

  property p_direct_write;
    @(posedge ref_clk) disable iff (rst)
    (!buffered && wr_en) |=> (active_q == $past(wr_data));
  endproperty
  a_direct_write: assert property (p_direct_write) // [R5]
    else $error("direct write did not reach active value");

  property p_buffered_hold;
    @(posedge ref_clk) disable iff (rst)
    (buffered && wr_en && !load) |=> $stable(active_q);
  endproperty
  a_buffered_hold: assert property (p_buffered_hold) // [R5]
    else $error("buffered value changed before the boundary");

  property p_boundary_load;
    @(posedge ref_clk) disable iff (rst)
    (buffered && load && !wr_en) |=> (active_q == $past(shadow_q));
  endproperty
  a_boundary_load: assert property (p_boundary_load) // [R5]
    else $error("shadow value not loaded at the period boundary");
endmodule

// [rtl/oc_map.svh]
// offsets, field positions, reset values and codes of the compare channel
// assumes a 4-bit register index and 16-bit register data
`ifndef OC_MAP_SVH
`define OC_MAP_SVH
`define OC_ADDR_CTRL 4'h0
`define OC_ADDR_PRIMARY 4'h1
`define OC_ADDR_SECONDARY 4'h2
`define OC_ADDR_TIMER 4'h3
`define OC_ADDR_TRIGGER 4'h4
`define OC_ADDR_STATUS 4'h5
`define OC_ADDR_MASK 4'h6
`define OC_CTRL_RESET 16'h0000
`define OC_CTRL_WMASK 16'h3C8F
`define OC_CTRL_RMASK 16'h3C9F
`define OC_TSEL_HI 12
`define OC_TSEL_LO 10
`define OC_FLT_EN_BIT 7
`define OC_FLT_STAT_BIT 4
`define OC_TRIG_MODE_BIT 3
`define OC_TSEL_PERIPH 3'h7
`define OC_TSEL_T1 3'h4
`define OC_TSEL_T5 3'h3
`define OC_TSEL_T4 3'h2
`define OC_IRQ_FAULT 0
`define OC_IRQ_PRIMARY 1
`define OC_IRQ_SECONDARY 2
`define OC_TIMER_TOP 16'hFFFF
`endif

// [rtl/oc_pkg.sv]
// types of the output compare channel
// assumes oc_map.svh for register constants; mode and shot encodings are set here
package oc_pkg;
  typedef enum logic [2:0] {
    MODE_OFF = 3'h0, MODE_SET_HIGH = 3'h1, MODE_SET_LOW = 3'h2,
    MODE_TOGGLE = 3'h3, MODE_DUAL_SHOT = 3'h4, MODE_DUAL_CONT = 3'h5,
    MODE_EDGE_PWM = 3'h6, MODE_CENTER_PWM = 3'h7
  } compare_mode_t;
  typedef enum logic [2:0] {
    SHOT_ARMED = 3'b001, SHOT_HALF = 3'b010, SHOT_DONE = 3'b100
  } shot_state_t;
  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] timer;
    logic trig;
    logic out;
    logic pin;
    shot_state_t shot;
    logic [2:0] status;
    logic [2:0] mask;
    logic [15:0] rdata;
    logic [1:0] flt_sync;
  } oc_state_t;
  typedef struct packed {
    logic [15:0] shadow;
    logic [15:0] active;
  } buf_state_t;
endpackage

// [rtl/output_compare_control_one.sv]
// output compare channel: control register, timer, fault and trigger
// assumes tick inputs and trigger_in come from logic on ref_clk;
// fault_input_pin is asynchronous and is synchronised here
`timescale 1ns/1ps
`include "oc_map.svh"

// Overview of operation
// (R1) clock select bits 12-10 pick timer tick
// (R2) fault enable bit 7 gates fault pin
// (R3) hardware sets and clears fault status bit 4
// (R4) trigger clear mode: clear on secondary match
// (R5) compare values double-buffered in PWM modes only
// (R6) PWM and disable mode encodings drive output
// (R7) single and double compare modes, toggle, force
// (R8) trigger flag low holds timer at zero
// (R9) unimplemented control bits read zero, ignore writes
module output_compare_control_one (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wr_data,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rd_data,
  input wire logic timer_one_clock,
  input wire logic timer_four_clock,
  input wire logic timer_five_clock,
  input wire logic trigger_in,
  input wire logic fault_input_pin,
  output logic compare_output_pin,
  output logic irq
);
  import oc_pkg::*;

  oc_state_t s_q, s_d;
  logic [15:0] pri_shadow, pri_active, sec_shadow, sec_active;
  logic tick, run, adv, pm, sm, period_end, pwm, fault_active;
  logic wr_ctrl, wr_trig;
  compare_mode_t mode, new_mode;

  // ------------------------------------------------------------
  // compare values
  // ------------------------------------------------------------
  compare_buffer u_primary (
    .ref_clk(ref_clk),
    .rst(rst),
    .wr_en(reg_wr && reg_addr == `OC_ADDR_PRIMARY),
    .wr_data(reg_wr_data),
    .buffered(pwm),
    .load(period_end),
    .shadow_q(pri_shadow),
    .active_q(pri_active)
  );

  compare_buffer u_secondary (
    .ref_clk(ref_clk),
    .rst(rst),
    .wr_en(reg_wr && reg_addr == `OC_ADDR_SECONDARY),
    .wr_data(reg_wr_data),
    .buffered(pwm),
    .load(period_end),
    .shadow_q(sec_shadow),
    .active_q(sec_active)
  );

  // ------------------------------------------------------------
  // timer tick and match events
  // ------------------------------------------------------------
  // reserved and unlisted selects give no tick, so the timer stalls
  always_comb begin
    case (s_q.ctrl[`OC_TSEL_HI:`OC_TSEL_LO])
      `OC_TSEL_PERIPH: tick = 1'b1; // [R1]
      `OC_TSEL_T1: tick = timer_one_clock; // [R1]
      `OC_TSEL_T5: tick = timer_five_clock; // [R1]
      `OC_TSEL_T4: tick = timer_four_clock; // [R1]
      default: tick = 1'b0;
    endcase
  end

  assign mode = compare_mode_t'(s_q.ctrl[2:0]);
  assign new_mode = compare_mode_t'(reg_wr_data[2:0]);
  assign pwm = (mode == MODE_EDGE_PWM) || (mode == MODE_CENTER_PWM); // [R5]
  assign run = s_q.trig && (mode != MODE_OFF);
  assign adv = run && tick;
  assign pm = adv && (s_q.timer == pri_active);
  assign sm = adv && (s_q.timer == sec_active);
  // edge PWM uses the secondary value as period, others free-run
  assign period_end = adv && ((mode == MODE_EDGE_PWM) ?
    (s_q.timer == sec_active) : (s_q.timer == `OC_TIMER_TOP));
  assign fault_active = s_q.ctrl[`OC_FLT_EN_BIT] && s_q.flt_sync[1]; // [R2]
  assign wr_ctrl = reg_wr && (reg_addr == `OC_ADDR_CTRL);
  assign wr_trig = reg_wr && (reg_addr == `OC_ADDR_TRIGGER);

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.flt_sync = {s_q.flt_sync[0], fault_input_pin};
    // control writes keep the hardware-owned fault bit
    if (wr_ctrl) begin
      s_d.ctrl = (reg_wr_data & `OC_CTRL_WMASK) | // [R9]
        (s_q.ctrl & ~`OC_CTRL_WMASK & `OC_CTRL_RMASK);
    end
    // fault status: set on fault, cleared once gone at a new period
    if (fault_active) begin
      s_d.ctrl[`OC_FLT_STAT_BIT] = 1'b1; // [R3]
    end else if (period_end) begin
      s_d.ctrl[`OC_FLT_STAT_BIT] = 1'b0; // [R3]
    end
    // trigger flag: clears first so a same-cycle set wins
    if (wr_trig && !reg_wr_data[0]) begin
      s_d.trig = 1'b0;
    end
    if (s_q.ctrl[`OC_TRIG_MODE_BIT] && sm) begin
      s_d.trig = 1'b0; // [R4]
    end
    if (trigger_in || (wr_trig && reg_wr_data[0])) begin
      s_d.trig = 1'b1;
    end
    // timer
    if (!s_q.trig || mode == MODE_OFF) begin
      s_d.timer = 16'h0000; // [R8]
    end else if (adv) begin
      s_d.timer = period_end ? 16'h0000 : s_q.timer + 16'h0001;
    end
    // output waveform per mode
    case (mode)
      MODE_OFF: s_d.out = 1'b0; // [R6]
      MODE_SET_HIGH, MODE_SET_LOW: begin
        if (pm && s_q.shot == SHOT_ARMED) begin
          s_d.out = (mode == MODE_SET_HIGH); // [R7]
          s_d.shot = SHOT_DONE;
        end
      end
      MODE_TOGGLE: if (pm) s_d.out = ~s_q.out; // [R7]
      MODE_DUAL_SHOT: begin
        if (pm && s_q.shot == SHOT_ARMED) begin
          s_d.out = 1'b1; // [R7]
          s_d.shot = SHOT_HALF;
        end else if (sm && s_q.shot == SHOT_HALF) begin
          s_d.out = 1'b0; // [R7]
          s_d.shot = SHOT_DONE;
        end
      end
      MODE_DUAL_CONT: begin
        if (pm) s_d.out = 1'b1; // [R7]
        else if (sm) s_d.out = 1'b0;
      end
      MODE_EDGE_PWM: begin
        if (pm) s_d.out = 1'b0; // [R6]
        else if (adv && s_q.timer == 16'h0000) s_d.out = 1'b1;
      end
      MODE_CENTER_PWM: begin
        if (pm) s_d.out = 1'b1; // [R6]
        else if (sm) s_d.out = 1'b0;
      end
      default: s_d.out = 1'b0;
    endcase
    // a control write that changes the mode re-initialises the output level and one-shots
    if (wr_ctrl && new_mode != mode) begin
      s_d.out = (new_mode == MODE_SET_LOW); // [R7]
      s_d.shot = SHOT_ARMED;
    end
    // a latched fault forces the pin low
    s_d.pin = s_d.out && !s_d.ctrl[`OC_FLT_STAT_BIT]; // [R3]
    // sticky status, write one to clear; new events win
    if (reg_wr && reg_addr == `OC_ADDR_STATUS) begin
      s_d.status = s_q.status & ~reg_wr_data[2:0];
    end
    if (fault_active && !s_q.ctrl[`OC_FLT_STAT_BIT]) begin
      s_d.status[`OC_IRQ_FAULT] = 1'b1;
    end
    if (pm) s_d.status[`OC_IRQ_PRIMARY] = 1'b1;
    if (sm) s_d.status[`OC_IRQ_SECONDARY] = 1'b1;
    if (reg_wr && reg_addr == `OC_ADDR_MASK) begin
      s_d.mask = reg_wr_data[2:0];
    end
    // read data stand only in the cycle after the strobe
    s_d.rdata = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        `OC_ADDR_CTRL: s_d.rdata = s_q.ctrl & `OC_CTRL_RMASK; // [R9]
        `OC_ADDR_PRIMARY: s_d.rdata = pri_shadow;
        `OC_ADDR_SECONDARY: s_d.rdata = sec_shadow;
        `OC_ADDR_TIMER: s_d.rdata = s_q.timer;
        `OC_ADDR_TRIGGER: s_d.rdata = {15'h0000, s_q.trig}; // [R8]
        `OC_ADDR_STATUS: s_d.rdata = {13'h0000, s_q.status};
        `OC_ADDR_MASK: s_d.rdata = {13'h0000, s_q.mask};
        default: s_d.rdata = 16'h0000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // state register and outputs
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '{ctrl: `OC_CTRL_RESET, shot: SHOT_ARMED, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rd_data = s_q.rdata;
  assign compare_output_pin = s_q.pin;
  assign irq = |(s_q.status & s_q.mask);

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_reserved_stall;
    @(posedge ref_clk) disable iff (rst)
    (s_q.ctrl[`OC_TSEL_HI:`OC_TSEL_LO] inside {3'h5, 3'h6} && run &&
      !wr_ctrl) |=> $stable(s_q.timer);
  endproperty
  a_reserved_stall: assert property (p_reserved_stall) // [R1]
    else $error("timer moved with a reserved clock select");

  property p_periph_count;
    @(posedge ref_clk) disable iff (rst)
    (s_q.ctrl[`OC_TSEL_HI:`OC_TSEL_LO] == `OC_TSEL_PERIPH && run &&
      mode != MODE_EDGE_PWM && s_q.timer != `OC_TIMER_TOP && !reg_wr)
      |=> (s_q.timer == $past(s_q.timer) + 16'h0001);
  endproperty
  a_periph_count: assert property (p_periph_count) // [R1]
    else $error("peripheral clock did not advance the timer");

  property p_fault_ignored;
    @(posedge ref_clk) disable iff (rst)
    (!s_q.ctrl[`OC_FLT_EN_BIT] && !s_q.ctrl[`OC_FLT_STAT_BIT])
      |=> !s_q.ctrl[`OC_FLT_STAT_BIT];
  endproperty
  a_fault_ignored: assert property (p_fault_ignored) // [R2]
    else $error("fault status set while fault input disabled");

  property p_fault_force;
    @(posedge ref_clk) disable iff (rst)
    fault_active |=> (s_q.ctrl[`OC_FLT_STAT_BIT] && !compare_output_pin);
  endproperty
  a_fault_force: assert property (p_fault_force) // [R3]
    else $error("fault did not latch status and force pin low");

  property p_auto_clear;
    @(posedge ref_clk) disable iff (rst)
    (s_q.ctrl[`OC_TRIG_MODE_BIT] && sm && !trigger_in && !wr_trig)
      |=> !s_q.trig;
  endproperty
  a_auto_clear: assert property (p_auto_clear) // [R4]
    else $error("trigger flag not cleared on secondary match");

  property p_manual_only;
    @(posedge ref_clk) disable iff (rst)
    (s_q.trig && !s_q.ctrl[`OC_TRIG_MODE_BIT] && !wr_trig) |=> s_q.trig;
  endproperty
  a_manual_only: assert property (p_manual_only) // [R4]
    else $error("trigger flag cleared by hardware in manual mode");

  property p_edge_low;
    @(posedge ref_clk) disable iff (rst)
    (mode == MODE_EDGE_PWM && pm && !reg_wr) |=> !compare_output_pin;
  endproperty
  a_edge_low: assert property (p_edge_low) // [R6]
    else $error("edge PWM output not low after primary match");

  property p_toggle;
    @(posedge ref_clk) disable iff (rst)
    (mode == MODE_TOGGLE && pm && !reg_wr) |=> (s_q.out != $past(s_q.out));
  endproperty
  a_toggle: assert property (p_toggle) // [R7]
    else $error("toggle mode did not toggle on primary match");

  property p_held_clear;
    @(posedge ref_clk) disable iff (rst)
    !s_q.trig |=> (s_q.timer == 16'h0000);
  endproperty
  a_held_clear: assert property (p_held_clear) // [R8]
    else $error("timer not held clear without trigger");

  property p_unimpl_zero;
    @(posedge ref_clk) disable iff (rst)
    (reg_rd && reg_addr == `OC_ADDR_CTRL)
      |=> ((reg_rd_data & ~`OC_CTRL_RMASK) == 16'h0000);
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) // [R9]
    else $error("unimplemented control bits read non-zero");
endmodule

// [testbench/fault_source_model.sv]
// partner model: external fault source and the load on the compare pin
// assumes the bench commands the fault level in step with ref_clk
`timescale 1ns/1ps
module fault_source_model (
  input wire logic ref_clk,
  input wire logic fault_on,
  input wire logic compare_output_pin,
  output logic fault_input_pin,
  output logic [7:0] rise_count
);
  logic pin_q = 1'b0;
  // fault edges land off the clock grid, as a real async source would
  initial fault_input_pin = 1'b0;
  always @(fault_on) fault_input_pin <= #13 fault_on;
  // the load counts rising edges, so a forced-low pin shows as no change
  initial rise_count = 8'h00;
  always @(posedge ref_clk) begin
    pin_q <= compare_output_pin;
    if (compare_output_pin && !pin_q)
      rise_count <= rise_count + 8'h01;
  end
endmodule

// [testbench/output_compare_control_one_test.sv]
// self-checking bench for the output compare channel
// assumes the register map of oc_map.svh and a 20 MHz ref_clk
`timescale 1ns/1ps
`include "oc_map.svh"
module output_compare_control_one_test;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wr_data = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rd_data;
  logic [2:0] ticks = 3'h0;
  logic trigger_in = 1'b0;
  logic fault_on = 1'b0;
  logic fault_input_pin;
  logic compare_output_pin;
  logic irq;
  logic [7:0] rise_count;
  logic [7:0] r0;
  logic [15:0] v;
  int bad_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int t0 = 0;

  // ----------------------------------------
  // clock, cycle count and hang guard
  // ----------------------------------------
  initial forever #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      bad_count++;
      test_done();
    end
  end

  output_compare_control_one dut (
    .ref_clk(ref_clk),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rd_data(reg_rd_data),
    .timer_one_clock(ticks[0]),
    .timer_four_clock(ticks[1]),
    .timer_five_clock(ticks[2]),
    .trigger_in(trigger_in),
    .fault_input_pin(fault_input_pin),
    .compare_output_pin(compare_output_pin),
    .irq(irq)
  );
  fault_source_model far_side (
    .ref_clk(ref_clk),
    .fault_on(fault_on),
    .compare_output_pin(compare_output_pin),
    .fault_input_pin(fault_input_pin),
    .rise_count(rise_count)
  );

  // ----------------------------------------
  // bus tasks and comparisons
  // ----------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe, so sample there
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rd_data;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [15:0] e);
    rd(a);
    check(v, e);
  endtask
  // e: cycles after the trigger edge; -1 waits unchecked
  task automatic wait_pin(input logic lvl, input int e);
    int n;
    n = 0;
    while (compare_output_pin !== lvl && n < 300) begin
      @(posedge ref_clk);
      #1 n++;
    end
    if (e >= 0)
      check(16'(cyc - t0), 16'(e));
  endtask
  // primary is rewritten just after the trigger: direct or shadowed
  task automatic run(input logic [2:0] m, input logic [15:0] p, s, np,
                     input int er, ef);
    wr(`OC_ADDR_TRIGGER, 16'h0000);
    wr(`OC_ADDR_CTRL, 16'h1C00);
    wr(`OC_ADDR_PRIMARY, p);
    wr(`OC_ADDR_SECONDARY, s);
    wr(`OC_ADDR_CTRL, {13'h0380, m});
    wr(`OC_ADDR_TRIGGER, 16'h0001);
    #1 t0 = cyc;
    wr(`OC_ADDR_PRIMARY, np);
    if (er > -2)
      wait_pin(1'b1, er);
    if (ef > -2)
      wait_pin(1'b0, ef);
  endtask
  task automatic tick(input logic [2:0] code, sel, input logic [15:0] e);
    wr(`OC_ADDR_TRIGGER, 16'h0000);
    wr(`OC_ADDR_CTRL, {3'h0, code, 10'h003});
    wr(`OC_ADDR_TRIGGER, 16'h0001);
    repeat (3) begin
      @(posedge ref_clk);
      ticks <= sel;
      @(posedge ref_clk);
      ticks <= 3'h0;
    end
    rdc(`OC_ADDR_TIMER, e);
  endtask
  task automatic test_done();
    $display("checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    rdc(`OC_ADDR_CTRL, 16'h0000);
    check({15'h0, compare_output_pin | irq}, 16'h0000);
    wr(`OC_ADDR_CTRL, 16'hFFFF);
    rdc(`OC_ADDR_CTRL, 16'h3C8F);
    wr(4'hF, 16'hFFFF);
    rdc(4'hF, 16'h0000);
    // every mode, with the rewrite exposing direct versus shadowed loads
    run(3'h3, 10, 40, 5, 6, -2);
    run(3'h6, 10, 40, 5, -1, 11);
    rdc(`OC_ADDR_PRIMARY, 16'h0005);
    run(3'h7, 3, 6, 3, 4, 7);
    run(3'h1, 4, 9, 4, 5, -2);
    run(3'h2, 4, 9, 4, -1, 5);
    run(3'h4, 3, 6, 3, 4, 7);
    run(3'h5, 3, 6, 3, 4, 7);
    rdc(`OC_ADDR_SECONDARY, 16'h0006);
    wr(`OC_ADDR_TRIGGER, 16'h0000);
    rdc(`OC_ADDR_STATUS, 16'h0006);
    check({15'h0, irq}, 16'h0000);
    wr(`OC_ADDR_MASK, 16'h0002);
    rdc(`OC_ADDR_MASK, 16'h0002);
    check({15'h0, irq}, 16'h0001);
    wr(`OC_ADDR_STATUS, 16'h0006);
    rdc(`OC_ADDR_STATUS, 16'h0000);
    check({15'h0, irq}, 16'h0000);
    run(3'h0, 3, 6, 3, -2, -2);
    rdc(`OC_ADDR_TIMER, 16'h0000);
    // tick sources, a reserved code and a wrong tick
    tick(3'h4, 3'h1, 16'h0003);
    tick(3'h3, 3'h4, 16'h0003);
    tick(3'h2, 3'h2, 16'h0003);
    tick(3'h6, 3'h7, 16'h0000);
    tick(3'h4, 3'h6, 16'h0000);
    // auto clear on secondary match, then software-only clear
    wr(`OC_ADDR_TRIGGER, 16'h0000);
    wr(`OC_ADDR_CTRL, 16'h1C00);
    wr(`OC_ADDR_SECONDARY, 16'h0005);
    wr(`OC_ADDR_CTRL, 16'h1C0B);
    wr(`OC_ADDR_TRIGGER, 16'h0001);
    repeat (12) @(posedge ref_clk);
    rdc(`OC_ADDR_TRIGGER, 16'h0000);
    rdc(`OC_ADDR_TIMER, 16'h0000);
    wr(`OC_ADDR_CTRL, 16'h1C03);
    @(posedge ref_clk);
    trigger_in <= 1'b1;
    @(posedge ref_clk);
    trigger_in <= 1'b0;
    repeat (12) @(posedge ref_clk);
    rdc(`OC_ADDR_TRIGGER, 16'h0001);
    // fault while enabled: status, forced low pin, clear at period end
    run(3'h6, 30, 40, 30, -2, -2);
    wr(`OC_ADDR_STATUS, 16'h0007);
    wr(`OC_ADDR_CTRL, 16'h1C86);
    fault_on <= 1'b1;
    repeat (8) @(posedge ref_clk);
    rdc(`OC_ADDR_CTRL, 16'h1C96);
    rd(`OC_ADDR_STATUS);
    check({15'h0, v[0]}, 16'h0001);
    r0 = rise_count;
    repeat (100) @(posedge ref_clk);
    check({8'h00, rise_count}, {8'h00, r0});
    fault_on <= 1'b0;
    repeat (90) @(posedge ref_clk);
    rdc(`OC_ADDR_CTRL, 16'h1C86);
    // fault ignored while the input is disabled
    wr(`OC_ADDR_CTRL, 16'h1C06);
    wr(`OC_ADDR_STATUS, 16'h0007);
    fault_on <= 1'b1;
    repeat (8) @(posedge ref_clk);
    rdc(`OC_ADDR_CTRL, 16'h1C06);
    rd(`OC_ADDR_STATUS);
    check({15'h0, v[0]}, 16'h0000);
    fault_on <= 1'b0;
    test_done();
  end
endmodule
